// ### shared/smbto_map.svh
/*
 * Constants for the serial-bus timeout and resolution block: timing figures,
 * derived cycle counts, resolution codes and reset values.
 * Assumes a 100 MHz system clock; included by the design files and the test bench.
 */
`ifndef SMBTO_MAP_SVH
`define SMBTO_MAP_SVH

`define SMBTO_CLK_HZ 100000000
`define SMBTO_TOUT_MIN_MS 25
`define SMBTO_TOUT_MAX_MS 35
// Threshold midway between min and max, 30 ms
`define SMBTO_TOUT_MS 30
`define SMBTO_TOUT_CYC ((`SMBTO_CLK_HZ / 1000) * `SMBTO_TOUT_MS)
`define SMBTO_GLITCH_NS 50
`define SMBTO_GLITCH_CYC ((`SMBTO_GLITCH_NS * (`SMBTO_CLK_HZ / 1000000) + 999) / 1000)
`define SMBTO_CAP_TOUT_BIT 6
`define SMBTO_RES_9 2'h0
`define SMBTO_RES_10 2'h1
`define SMBTO_RES_11 2'h2
`define SMBTO_RES_12 2'h3
`define SMBTO_RES_RST `SMBTO_RES_10

`endif

// ### shared/smbto_pkg.sv
/*
 * Types for the serial-bus timeout block.
 * Assumes the constant header is on the include path.
 */
package smbto_pkg;
    typedef logic [1:0] smbto_res_t;

    // Bit-level protocol states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_XFER = 4'h2,
        ST_ACK = 4'h4,
        ST_TOUT = 4'h8
    } smbto_state_e;

    // Filtered bus lines travel together
    typedef struct packed {
        logic scl;
        logic sda;
    } smbto_bus_s;
endpackage : smbto_pkg

// ### design/smbto_glitch_filter.sv
/*
 * Two-flop synchroniser and glitch filter for one bus line.
 * Assumes the input comes from a pin outside the clock domain.
 */
`timescale 1ns/1ps
`include "smbto_map.svh"
module smbto_glitch_filter #(
    parameter int unsigned FILT_CYC = `SMBTO_GLITCH_CYC,
    parameter bit RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Line
    input wire logic lineIn,
    output logic lineOut
);
    // Counter is eight bits wide, so longer filters cannot be served
    if (FILT_CYC < 1 || FILT_CYC > 250) begin : g_bad_filt
        $error("FILT_CYC out of range");
    end

    logic sync1_r;
    logic sync2_r;
    logic [7:0] cnt_r;

    // Synchroniser; first flop read only by the second
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sync1_r <= RST_VAL;
            sync2_r <= RST_VAL;
        end else begin
            sync1_r <= lineIn;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_r <= 8'h00;
            lineOut <= RST_VAL;
        end else if (sync2_r == lineOut) begin
            cnt_r <= 8'h00;
        end else if (cnt_r >= 8'(FILT_CYC)) begin
            lineOut <= sync2_r; // Held longer than a glitch
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule : smbto_glitch_filter

// ### design/smbto_core.sv
/*
 * Slave-side serial bus front end: filtered pins, bit shifter strobed by
 * the serial clock, clock-low timeout with protocol reset, resolution setting.
 * Assumes byte-level decoding lies outside and talks through the byte ports.
 */
`timescale 1ns/1ps
`include "smbto_map.svh"
module smbto_core
    import smbto_pkg::*;
#(
    parameter int unsigned TOUT_CYC = `SMBTO_TOUT_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic sclOe,
    // Byte side
    input wire logic [7:0] txByte,
    input wire logic ackEn,
    output logic [7:0] rxByte,
    output logic rxValid,
    output logic startSeen,
    output logic stopSeen,
    // Resolution and capability
    input wire logic resWrite,
    input wire smbto_res_t resWdata,
    output smbto_res_t resSel,
    output logic [7:0] capBits,
    output logic timeoutPulse,
    output logic busActive
);
    // Threshold compare needs at least two counts
    if (TOUT_CYC < 2) begin : g_bad_tout
        $error("TOUT_CYC too small");
    end

    smbto_bus_s bus;
    smbto_bus_s busPrev_r;
    logic sclFilt;
    logic sdaFilt;
    smbto_state_e state_r;
    logic [31:0] lowCnt_r;
    logic [3:0] bitCnt_r;
    logic [7:0] shift_r;
    logic [7:0] txShift_r;
    logic sdaDrv_r;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic toutHit;

    // Pin filtering for both lines
    smbto_glitch_filter #(.FILT_CYC(`SMBTO_GLITCH_CYC), .RST_VAL(1'b1)) uScl (
        .clk_sys(clk_sys), .resetn(resetn), .lineIn(sclIn), .lineOut(sclFilt));
    smbto_glitch_filter #(.FILT_CYC(`SMBTO_GLITCH_CYC), .RST_VAL(1'b1)) uSda (
        .clk_sys(clk_sys), .resetn(resetn), .lineIn(sdaIn), .lineOut(sdaFilt));
    // One driver for the whole struct
    assign bus = '{scl: sclFilt, sda: sdaFilt};

    // Edge history of filtered lines
    always_ff @(posedge clk_sys) begin
        if (!resetn) busPrev_r <= '{scl: 1'b1, sda: 1'b1};
        else busPrev_r <= bus;
    end

    assign sclRise = bus.scl && !busPrev_r.scl;
    assign sclFall = !bus.scl && busPrev_r.scl;
    assign startCond = bus.scl && busPrev_r.scl && busPrev_r.sda && !bus.sda;
    assign stopCond = bus.scl && busPrev_r.scl && !busPrev_r.sda && bus.sda;

    // low-time counter restarts on rising clock
    always_ff @(posedge clk_sys) begin
        if (!resetn) lowCnt_r <= 32'h0;
        else if (bus.scl || sclRise) lowCnt_r <= 32'h0;
        else if (lowCnt_r < TOUT_CYC) lowCnt_r <= lowCnt_r + 32'h1;
    end
    assign toutHit = !bus.scl && (lowCnt_r == TOUT_CYC - 1);

    // abort on long clock low; back to idle once the clock rises
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
        end else if (toutHit && state_r != ST_IDLE) begin
            state_r <= ST_TOUT;
        end else begin
            unique case (state_r)
                ST_IDLE: if (startCond) state_r <= ST_XFER;
                ST_XFER: begin
                    if (stopCond) state_r <= ST_IDLE;
                    else if (startCond) state_r <= ST_XFER;
                    else if (sclFall && bitCnt_r == 4'h8) state_r <= ST_ACK;
                end
                ST_ACK: begin
                    if (stopCond) state_r <= ST_IDLE;
                    else if (sclFall) state_r <= ST_XFER;
                end
                // ready for START once the clock rises
                ST_TOUT: if (bus.scl) state_r <= ST_IDLE;
            endcase
        end
    end

    // bits shift only on serial clock edges
    always_ff @(posedge clk_sys) begin
        if (!resetn || state_r == ST_IDLE || state_r == ST_TOUT || startCond) begin
            bitCnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (state_r == ST_XFER && sclRise && bitCnt_r < 4'h8) begin
            shift_r <= {shift_r[6:0], bus.sda};
            bitCnt_r <= bitCnt_r + 4'h1;
        end else if (state_r == ST_ACK && sclFall) begin
            bitCnt_r <= 4'h0;
        end
    end

    // Received byte, registered
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rxByte <= 8'h00;
            rxValid <= 1'b0;
        end else begin
            rxValid <= state_r == ST_XFER && sclFall && bitCnt_r == 4'h8 && !toutHit;
            if (state_r == ST_XFER && sclFall && bitCnt_r == 4'h8) rxByte <= shift_r;
        end
    end

    // data out changes on falling clock; released on timeout
    always_ff @(posedge clk_sys) begin
        if (!resetn || toutHit || state_r == ST_TOUT || state_r == ST_IDLE) begin
            sdaDrv_r <= 1'b0;
            txShift_r <= txByte;
        end else if (sclFall) begin
            if (state_r == ST_XFER && bitCnt_r == 4'h8) begin
                sdaDrv_r <= ackEn; // Pull low to acknowledge
                txShift_r <= txByte;
            end else begin
                sdaDrv_r <= 1'b0;
            end
        end
    end

    // Open-drain data: only ever drive low
    assign sdaOut = 1'b0;
    assign sdaOe = sdaDrv_r;
    assign sclOe = 1'b0;

    // Bus event pulses and status, registered
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            startSeen <= 1'b0;
            stopSeen <= 1'b0;
            timeoutPulse <= 1'b0;
            busActive <= 1'b0;
        end else begin
            startSeen <= startCond;
            stopSeen <= stopCond;
            timeoutPulse <= toutHit && state_r != ST_IDLE;
            busActive <= state_r != ST_IDLE;
        end
    end

    // resolution defaults to 10 bits; timeout leaves it alone
    always_ff @(posedge clk_sys) begin
        if (!resetn) resSel <= `SMBTO_RES_RST;
        else if (resWrite) resSel <= resWdata;
    end

    assign capBits = 8'(1) << `SMBTO_CAP_TOUT_BIT;

    // Assertions
    property p_tout_release;
        @(posedge clk_sys) disable iff (!resetn)
        (toutHit && state_r != ST_IDLE) |=> (!sdaOe && state_r == ST_TOUT);
    endproperty
    a_tout_release: assert property (p_tout_release) else $error("no release on timeout");

    property p_tout_idle;
        @(posedge clk_sys) disable iff (!resetn)
        (state_r == ST_TOUT && bus.scl) |=> state_r == ST_IDLE;
    endproperty
    a_tout_idle: assert property (p_tout_idle) else $error("no idle after timeout");

    property p_cap;
        @(posedge clk_sys) capBits[`SMBTO_CAP_TOUT_BIT];
    endproperty
    a_cap: assert property (p_cap) else $error("capability bit clear");

    property p_no_stretch;
        @(posedge clk_sys) disable iff (!resetn) !sclOe;
    endproperty
    a_no_stretch: assert property (p_no_stretch) else $error("clock driven");

    property p_shift_on_rise;
        @(posedge clk_sys) disable iff (!resetn)
        (bitCnt_r != $past(bitCnt_r) && bitCnt_r != 4'h0) |-> $past(sclRise);
    endproperty
    a_shift_on_rise: assert property (p_shift_on_rise) else $error("shift off clock");

    property p_res_default;
        @(posedge clk_sys) $rose(resetn) |-> resSel == `SMBTO_RES_RST;
    endproperty
    a_res_default: assert property (p_res_default) else $error("bad reset resolution");

    property p_cnt_restart;
        @(posedge clk_sys) disable iff (!resetn) sclRise |=> lowCnt_r == 32'h0;
    endproperty
    a_cnt_restart: assert property (p_cnt_restart) else $error("counter not restarted");

    property p_res_kept;
        @(posedge clk_sys) disable iff (!resetn)
        (timeoutPulse && !$past(resWrite)) |-> $stable(resSel);
    endproperty
    a_res_kept: assert property (p_res_kept) else $error("timeout touched resolution");

    c_timeout: cover property (@(posedge clk_sys) disable iff (!resetn) timeoutPulse);
    c_byte: cover property (@(posedge clk_sys) disable iff (!resetn) rxValid);
    c_ack: cover property (@(posedge clk_sys) disable iff (!resetn) sdaOe);
    c_stop: cover property (@(posedge clk_sys) disable iff (!resetn) stopSeen);
endmodule : smbto_core

// ### tb/smbto_host_model.sv
/*
 * Bus host model: drives the clock push-pull, pulls data low open-drain.
 * Assumes the bench resolves the data wire with a pull-up.
 */
`timescale 1ns/1ps
module smbto_host_model #(
    parameter int HALF = 20
) (
    // Clock
    input wire logic clk_sys,
    // Wire
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaLow
);
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : waitCyc
    // Data falls while clock high; also a repeated start
    task automatic busStart();
        sdaLow <= 1'b0;
        waitCyc(HALF);
        sclOut <= 1'b1;
        waitCyc(HALF);
        sdaLow <= 1'b1;
        waitCyc(HALF);
        sclOut <= 1'b0;
        waitCyc(8);
    endtask : busStart
    task automatic busStop();
        sdaLow <= 1'b1;
        waitCyc(HALF);
        sclOut <= 1'b1;
        waitCyc(HALF);
        sdaLow <= 1'b0;
        waitCyc(HALF);
    endtask : busStop
    // Data moves only with clock low, gap after the fall
    task automatic sendByte(input logic [7:0] b, input bit withAck, output logic ack);
        ack = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sdaLow <= ~b[i];
            waitCyc(HALF);
            sclOut <= 1'b1;
            waitCyc(HALF);
            sclOut <= 1'b0;
            waitCyc(8);
        end
        sdaLow <= 1'b0;
        if (withAck) begin
            waitCyc(HALF);
            sclOut <= 1'b1;
            waitCyc(HALF / 2);
            ack = (sdaLine === 1'b0);
            waitCyc(HALF / 2);
            sclOut <= 1'b0;
            waitCyc(8);
        end
    endtask : sendByte
    // forced low, longer than the top bound
    task automatic holdLow(input int n);
        sclOut <= 1'b0;
        waitCyc(n);
    endtask : holdLow
    // Short low pulse on data
    task automatic glitchSda(input int n);
        sdaLow <= 1'b1;
        waitCyc(n);
        sdaLow <= 1'b0;
        waitCyc(HALF);
    endtask : glitchSda
endmodule : smbto_host_model

// ### tb/test_smbto_core.sv
/*
 * Self-checking bench for the bus front end with a host model.
 * Assumes a shortened timeout parameter; expectations from constants.
 */
`timescale 1ns/1ps
`include "smbto_map.svh"
module test_smbto_core
    import smbto_pkg::*;
;
    localparam int TOUT = 200;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ackEn = 1'b0;
    logic [7:0] txByte = 8'h00;
    logic resWrite = 1'b0;
    smbto_res_t resWdata = 2'h0;
    logic sdaOut, sdaOe, sclOe, rxValid, startSeen, stopSeen, timeoutPulse, busActive;
    logic hostScl, hostSdaLow, ack;
    logic [7:0] rxByte, capBits, b;
    smbto_res_t resSel, code;
    wire sclIn = hostScl & ~sclOe;
    wire sdaIn = ~(hostSdaLow | (sdaOe & ~sdaOut));
    int seed = 32'h5fe3b6fb;
    int bad_count = 0;
    int compares = 0;
    int nRx = 0, nStart = 0, nStop = 0, nTout = 0;
    always #5 clk_sys = ~clk_sys;
    // Pulse tallies
    always @(posedge clk_sys) begin
        nRx += (rxValid === 1'b1);
        nStart += (startSeen === 1'b1);
        nStop += (stopSeen === 1'b1);
        nTout += (timeoutPulse === 1'b1);
    end
    smbto_core #(.TOUT_CYC(TOUT)) u_smbto_core (.clk_sys(clk_sys), .resetn(resetn),
        .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOe(sclOe),
        .txByte(txByte), .ackEn(ackEn), .rxByte(rxByte), .rxValid(rxValid),
        .startSeen(startSeen), .stopSeen(stopSeen), .resWrite(resWrite),
        .resWdata(resWdata), .resSel(resSel), .capBits(capBits),
        .timeoutPulse(timeoutPulse), .busActive(busActive));
    smbto_host_model #(.HALF(20)) u_smbto_host_model (.clk_sys(clk_sys), .sdaLine(sdaIn),
        .sclOut(hostScl), .sdaLow(hostSdaLow));
    task automatic check(input string what, input logic [7:0] expv, input logic [7:0] got);
        compares++;
        if (got !== expv) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, expv, got);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // Expected setting code for a bit count
    function automatic smbto_res_t codeOf(input int bits);
        return smbto_res_t'(bits - 9);
    endfunction : codeOf
    task automatic writeRes(input smbto_res_t c);
        @(posedge clk_sys);
        resWdata <= c;
        resWrite <= 1'b1;
        @(posedge clk_sys);
        resWrite <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : writeRes
    // Watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        #1;
        check("resSel", {6'h0, `SMBTO_RES_RST}, {6'h0, resSel});
        check("capBits", 8'h40, capBits);
        check("sclOe", 8'h00, {7'h0, sclOe});
        check("sdaOut", 8'h00, {7'h0, sdaOut});
        // Every setting, then random ones
        for (int i = 0; i < 8; i++) begin
            code = (i < 4) ? codeOf(12 - i) : smbto_res_t'($random(seed));
            writeRes(code);
            check("resSel", {6'h0, code}, {6'h0, resSel});
        end
        $display("test resolution done");
        for (int i = 0; i < 6; i++) begin
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            ackEn <= (i != 2);
            txByte <= 8'($random(seed));
            u_smbto_host_model.busStart();
            u_smbto_host_model.sendByte(b, 1'b1, ack);
            check("rxByte", b, rxByte);
            check("ack", {7'h0, i != 2}, {7'h0, ack});
            check("sclOe", 8'h00, {7'h0, sclOe});
            u_smbto_host_model.busStop();
        end
        check("rx count", 8'd6, 8'(nRx));
        check("stop count", 8'd6, 8'(nStop));
        $display("test bytes done");
        // Widest glitch that must still be swallowed
        u_smbto_host_model.glitchSda(5);
        check("start count", 8'd6, 8'(nStart));
        u_smbto_host_model.holdLow(TOUT + 60);
        u_smbto_host_model.waitCyc(20);
        check("idle timeout", 8'd0, 8'(nTout));
        u_smbto_host_model.sclOut <= 1'b1;
        ackEn <= 1'b1;
        u_smbto_host_model.waitCyc(40);
        u_smbto_host_model.busStart();
        u_smbto_host_model.sendByte(8'h3c, 1'b0, ack);
        // Filtered clock fall lags the pin, let the ack drive settle
        u_smbto_host_model.waitCyc(4);
        check("ack drive", 8'h01, {7'h0, sdaOe});
        u_smbto_host_model.holdLow(TOUT + 60);
        check("timeout count", 8'd1, 8'(nTout));
        check("sdaOe freed", 8'h00, {7'h0, sdaOe});
        u_smbto_host_model.busStop();
        u_smbto_host_model.waitCyc(20);
        check("busActive", 8'h00, {7'h0, busActive});
        check("resSel kept", {6'h0, code}, {6'h0, resSel});
        u_smbto_host_model.busStart();
        u_smbto_host_model.sendByte(8'h96, 1'b1, ack);
        check("rxByte after", 8'h96, rxByte);
        u_smbto_host_model.busStop();
        $display("test timeout done");
        tally_and_finish();
    end
endmodule : test_smbto_core
